// [dprr_top.sv]
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
// How it works
// R1: Page zero starts with default patterns; link writes persist until reset.
// R2: Page zero reads may use short or long column spacing.
// R3: Pages one to three reads need long column spacing.
// R4: Controller locks loop, precharges all, waits before entering the mode; the testbench issues no precharge, as reset leaves every bank idle.
// R5: Mode register three bit 2 enables the mode; bits 1:0 pick page.
// R6: Bits 12:11 pick serial, parallel or staggered; code 11 never taken.
// R7: Controller waits both mode-set delays before the first pattern read.
// R8: While enabled, every read goes to the bank-addressed location; a read at a full queue with no burst starting is dropped and sets the overflow flag.
// R9: Fixed burst eight or chop four; on-the-fly uses A12.
// R10: Burst eight order 0..7; chop four returns beats 0..3 or 4..7.
// R11: A1:A0 are zero; A10 and other inputs are ignored.
// R12: Data starts one read latency, additive plus column, after the read.
// R13: Controller waits exit delay, clears bit 2, waits update delay.
// R14: Controller uses serial format for readout pages.
// R15: Strobes run with the data as in a normal read, with preamble.
// R16: Serial format puts the same byte on all lanes, MSB first.
// R17: Parallel format reads only location zero.
// R18: Parallel format holds one bit per lane, lane 0 bit 7.
// R19: Sixteen-lane parts repeat the byte on the upper lanes.
// R20: Bus inversion setting is ignored; data is never inverted.
// R21: Staggered lane n returns location addressed plus n, modulo four.
// R22: Controller never issues the reserved code or bad address combinations; the testbench issues format code 11 once to check the error flag.
module dprr_top import dprr_pkg::*; #(
   parameter int DQ_W = 16,
   parameter int QD = 8
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Command side of the memory link
   input wire logic ck_i,
   input wire logic mrs_i,
   input wire logic rd_i,
   input wire logic wr_i,
   input wire logic bg0_i,
   input wire logic [1:0] ba_i,
   input wire logic [ADDR_W-1:0] addr_i,
   // Data side of the memory link
   output logic [DQ_W-1:0] dq_o,
   output logic dq_oe_o,
   output logic dqs_o,
   output logic dqs_oe_o
);

   localparam int QA = $clog2(QD);
   localparam int QC = $clog2(QD + 1);

   logic [PIN_W-1:0] sync1_r, sync2_r, sync3_r;
   logic ck_lvl_r, ck_rise, ck_fall;
   logic c_mrs, c_rd, c_wr;
   logic [2:0] c_mr;
   logic [1:0] c_ba;
   logic [ADDR_W-1:0] c_addr;
   logic mpr_en_r, dbi_r, fmt_err_r, ovf_r;
   logic [1:0] page_r, bl_r;
   dprr_fmt_t fmt_r;
   logic [LAT_W-1:0] ctl_cl_r, ctl_al_r;
   logic ctl_pre_r;
   logic [7:0] rl, pre_len, ck_cnt_r;
   logic [7:0] q_due_r [QD];
   logic [1:0] q_loc_r [QD];
   logic q_chop_r [QD];
   logic q_half_r [QD];
   logic [QA-1:0] q_wp_r, q_rp_r;
   logic [QC-1:0] q_cnt_r;
   logic push, pop, start, pre_go, rd_chop;
   dprr_state_t state_r;
   logic [2:0] beat_r, bst_last_r, ui_nx;
   logic [31:0] bst_word_r, page_word_r, mem_rdata, rd_val;
   dprr_fmt_t bst_fmt_r;
   logic [1:0] bst_loc_r;
   logic bst_half_r, rd_mode_q_r, rd_err, acc_done, apb_we, pat_sel;
   logic lnk_pend_r;
   logic [1:0] lnk_loc_r;
   logic [7:0] lnk_data_r;
   logic mem_we;
   logic [1:0] mem_waddr, mem_raddr;
   logic [3:0] mem_wbe;
   logic [31:0] mem_wdata, ctrl_word, stat_word;

   function automatic logic is_pat(input logic [7:0] a);
      return a[7:4] == REG_PAT[7:4];
   endfunction

   // Lane values of one beat for the given format and start location.
   function automatic logic [DQ_W-1:0] lanes(input logic [31:0] w,
         input dprr_fmt_t f, input logic [1:0] loc, input logic [2:0] ui);
      logic [1:0] sel;
      logic [7:0] b;
      lanes = '0;
      for (int i = 0; i < DQ_W; i++) begin
         // R21: staggered location offset
         sel = (f == FMT_STAGGER) ? 2'(loc + 2'(i)) : loc;
         b = w[8*sel +: 8];
         if (f == FMT_PARALLEL) begin
            // R18 R19: one bit per lane
            lanes[i] = w[7 - (i % 8)];
         end else begin
            lanes[i] = b[3'h7 - ui];
         end
      end
   endfunction

   // All link pins are asynchronous to mclk_i.
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         sync1_r <= '0;
         sync2_r <= '0;
         sync3_r <= '0;
      end else begin
         sync1_r <= {ck_i, mrs_i, rd_i, wr_i, bg0_i, ba_i, addr_i};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   assign ck_rise = sync2_r[P_CK] & sync3_r[P_CK] & ~ck_lvl_r;
   assign ck_fall = ~sync2_r[P_CK] & ~sync3_r[P_CK] & ck_lvl_r;
   assign c_mrs = sync3_r[P_MRS];
   assign c_rd = sync3_r[P_RD];
   assign c_wr = sync3_r[P_WR];
   assign c_ba = sync3_r[P_BA +: 2];
   assign c_mr = {sync3_r[P_BG0], c_ba};
   assign c_addr = sync3_r[P_ADDR +: ADDR_W];

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         ck_lvl_r <= 1'b0;
         ck_cnt_r <= '0;
      end else begin
         if (ck_rise || ck_fall) begin
            ck_lvl_r <= ~ck_lvl_r;
         end
         if (ck_rise) begin
            ck_cnt_r <= ck_cnt_r + 8'h01;
         end
      end
   end

   // Mode registers seen on the link.
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         mpr_en_r <= 1'b0;
         page_r <= '0;
         fmt_r <= FMT_SERIAL;
         bl_r <= BL_FIX8;
         dbi_r <= 1'b0;
      end else if (ck_rise && c_mrs) begin
         unique case (c_mr)
            MR_ZERO: bl_r <= c_addr[M0_BL +: 2];
            // R5: enable and page
            MR_THREE: begin
               mpr_en_r <= c_addr[M3_EN];
               page_r <= c_addr[M3_PAGE +: 2];
               // R6: reserved code is not taken
               if (c_addr[M3_FMT +: 2] != FMT_RSVD) begin
                  fmt_r <= dprr_fmt_t'(c_addr[M3_FMT +: 2]);
               end
            end
            MR_FIVE: dbi_r <= c_addr[M5_DBI];
            default: ;
         endcase
      end
   end

   // R9: fixed chop, fixed eight, or A12 when on the fly
   assign rd_chop = (bl_r == BL_FIX4) || (bl_r == BL_OTF && !c_addr[A_CHOP]);
   assign rl = 8'(ctl_cl_r) + 8'(ctl_al_r);
   assign pre_len = ctl_pre_r ? 8'h02 : 8'h01;
   // R8: reads in the mode go to a pattern location
   assign push = ck_rise && c_rd && mpr_en_r && (q_cnt_r != QC'(QD) || pop);
   assign start = ck_rise && q_cnt_r != '0 && q_due_r[q_rp_r] == ck_cnt_r;
   assign pop = start;
   assign pre_go = q_cnt_r != '0 && q_due_r[q_rp_r] == 8'(ck_cnt_r + pre_len);

   // Pending reads wait here until their read latency expires.
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         q_wp_r <= '0;
         q_rp_r <= '0;
         q_cnt_r <= '0;
         for (int i = 0; i < QD; i++) begin
            q_due_r[i] <= '0;
            q_loc_r[i] <= '0;
            q_chop_r[i] <= 1'b0;
            q_half_r[i] <= 1'b0;
         end
      end else begin
         if (push) begin
            // R12: due one read latency later
            q_due_r[q_wp_r] <= 8'(ck_cnt_r + rl);
            q_loc_r[q_wp_r] <= c_ba;
            q_chop_r[q_wp_r] <= rd_chop;
            // R10: chop half from A2
            q_half_r[q_wp_r] <= rd_chop & c_addr[A_HALF];
            q_wp_r <= QA'(q_wp_r + 1'b1);
         end
         if (pop) begin
            q_rp_r <= QA'(q_rp_r + 1'b1);
         end
         q_cnt_r <= QC'(q_cnt_r + QC'(push) - QC'(pop));
      end
   end

   // R10: chop from the upper half starts at beat 4
   assign ui_nx = bst_half_r ? {1'b1, 2'(beat_r + 3'h1)} : 3'(beat_r + 3'h1);

   // Output burst; data changes on both link clock edges.
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         state_r <= ST_IDLE;
         beat_r <= '0;
         bst_last_r <= LAST_BL8;
         bst_word_r <= '0;
         bst_fmt_r <= FMT_SERIAL;
         bst_loc_r <= '0;
         bst_half_r <= 1'b0;
         dq_o <= '0;
         dq_oe_o <= 1'b0;
         dqs_o <= 1'b0;
         dqs_oe_o <= 1'b0;
      end else if (start) begin
         // R12: first beat at the due edge
         state_r <= ST_BURST;
         beat_r <= '0;
         bst_word_r <= page_word_r;
         bst_fmt_r <= fmt_r;
         bst_loc_r <= q_loc_r[q_rp_r];
         bst_half_r <= q_half_r[q_rp_r];
         bst_last_r <= q_chop_r[q_rp_r] ? LAST_BC4 : LAST_BL8;
         // R20: bus inversion never applied
         dq_o <= lanes(page_word_r, fmt_r, q_loc_r[q_rp_r],
                       {q_half_r[q_rp_r], 2'h0});
         dq_oe_o <= 1'b1;
         // R15: strobe edge with each beat
         dqs_o <= 1'b1;
         dqs_oe_o <= 1'b1;
      end else if ((ck_rise || ck_fall) && state_r == ST_BURST &&
                   beat_r != bst_last_r) begin
         // R16: serial, parallel and staggered lanes
         beat_r <= 3'(beat_r + 3'h1);
         dq_o <= lanes(bst_word_r, bst_fmt_r, bst_loc_r, ui_nx);
         dqs_o <= ~dqs_o;
      end else if (ck_rise && pre_go) begin
         // R15: read preamble holds the strobe low
         state_r <= ST_PRE;
         dq_oe_o <= 1'b0;
         dqs_o <= 1'b0;
         dqs_oe_o <= 1'b1;
      end else if (ck_rise && state_r == ST_BURST) begin
         state_r <= ST_IDLE;
         dq_oe_o <= 1'b0;
         dqs_o <= 1'b0;
         dqs_oe_o <= 1'b0;
      end
   end

   // Pattern writes from the link; only page zero takes them.
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         lnk_pend_r <= 1'b0;
         lnk_loc_r <= '0;
         lnk_data_r <= '0;
      end else if (ck_rise && c_wr && mpr_en_r && page_r == 2'h0) begin
         // R1: link writes page zero
         lnk_pend_r <= 1'b1;
         lnk_loc_r <= c_ba;
         lnk_data_r <= c_addr[7:0];
      end else if (!apb_we) begin
         lnk_pend_r <= 1'b0;
      end
   end

   // An APB write wins the port; the link write waits one cycle.
   assign mem_we = apb_we | lnk_pend_r;
   assign mem_waddr = apb_we ? paddr_i[3:2] : 2'h0;
   assign mem_wbe = apb_we ? 4'hf : 4'(4'h1 << lnk_loc_r);
   assign mem_wdata = apb_we ? pwdata_i : {4{lnk_data_r}};
   assign pat_sel = psel_i && is_pat(paddr_i);
   assign mem_raddr = pat_sel ? paddr_i[3:2] : page_r;

   dprr_pat_mem #(.W(32), .D(4), .AW(2)) u_mem (
      .clk_i(mclk_i),
      .rst_i(sys_rst_i),
      .we_i(mem_we),
      .waddr_i(mem_waddr),
      .wbe_i(mem_wbe),
      .wdata_i(mem_wdata),
      .raddr_i(mem_raddr),
      .rdata_o(mem_rdata)
   );

   // The burst copy is refreshed only while APB leaves the read port.
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rd_mode_q_r <= 1'b0;
         page_word_r <= PAT_PAGE0_RST;
      end else begin
         rd_mode_q_r <= ~pat_sel;
         if (rd_mode_q_r && !pat_sel) begin
            page_word_r <= mem_rdata;
         end
      end
   end

   assign acc_done = psel_i && penable_i && pready_o;
   assign apb_we = acc_done && pwrite_i && !rd_err && pat_sel;

   always_comb begin
      ctrl_word = '0;
      ctrl_word[CTL_CL_LSB +: LAT_W] = ctl_cl_r;
      ctrl_word[CTL_AL_LSB +: LAT_W] = ctl_al_r;
      ctrl_word[CTL_PRE_BIT] = ctl_pre_r;
      stat_word = '0;
      stat_word[SB_EN] = mpr_en_r;
      stat_word[SB_PAGE +: 2] = page_r;
      stat_word[SB_FMT +: 2] = fmt_r;
      stat_word[SB_BL +: 2] = bl_r;
      stat_word[SB_DBI] = dbi_r;
      stat_word[SB_BUSY] = state_r != ST_IDLE;
      stat_word[SB_FERR] = fmt_err_r;
      stat_word[SB_OVF] = ovf_r;
   end

   always_comb begin
      rd_val = '0;
      rd_err = 1'b0;
      if (paddr_i[1:0] != 2'h0) begin
         rd_err = 1'b1;
      end else if (is_pat(paddr_i)) begin
         rd_val = mem_rdata;
         rd_err = pwrite_i && paddr_i[3:2] == 2'h0;
      end else if (paddr_i == REG_CTRL) begin
         rd_val = ctrl_word;
      end else if (paddr_i == REG_STAT) begin
         rd_val = stat_word;
      end else begin
         rd_err = 1'b1;
      end
   end

   // Every access answers in its second access cycle.
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         pready_o <= 1'b0;
         prdata_o <= '0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= psel_i && penable_i && !pready_o;
         if (psel_i && penable_i && !pready_o) begin
            prdata_o <= (pwrite_i || rd_err) ? '0 : rd_val;
            pslverr_o <= rd_err;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         ctl_cl_r <= CL_RST;
         ctl_al_r <= AL_RST;
         ctl_pre_r <= PRE_RST;
      end else if (acc_done && pwrite_i && paddr_i == REG_CTRL) begin
         ctl_cl_r <= pwdata_i[CTL_CL_LSB +: LAT_W];
         ctl_al_r <= pwdata_i[CTL_AL_LSB +: LAT_W];
         ctl_pre_r <= pwdata_i[CTL_PRE_BIT];
      end
   end

   // Sticky flags: a new event in the clearing cycle is kept.
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         fmt_err_r <= 1'b0;
         ovf_r <= 1'b0;
      end else begin
         fmt_err_r <= (ck_rise && c_mrs && c_mr == MR_THREE &&
                       c_addr[M3_FMT +: 2] == FMT_RSVD) ||
                      (fmt_err_r && !(acc_done && pwrite_i &&
                       paddr_i == REG_STAT && pwdata_i[SB_FERR]));
         ovf_r <= (ck_rise && c_rd && mpr_en_r && !push) ||
                  (ovf_r && !(acc_done && pwrite_i &&
                   paddr_i == REG_STAT && pwdata_i[SB_OVF]));
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   property p_mode_en;
      (ck_rise && c_mrs && c_mr == MR_THREE) |=>
         mpr_en_r == $past(c_addr[M3_EN]) &&
         page_r == $past(c_addr[M3_PAGE +: 2]);
   endproperty
   a_mode_en: assert property (p_mode_en) // R5
      else $error("mode register three not applied");

   property p_no_rsvd;
      fmt_r != FMT_RSVD;
   endproperty
   a_no_rsvd: assert property (p_no_rsvd) // R6
      else $error("reserved readout format taken");

   property p_redirect;
      (ck_rise && c_rd && mpr_en_r && q_cnt_r == '0) |=> q_cnt_r == QC'(1);
   endproperty
   a_redirect: assert property (p_redirect) // R8
      else $error("pattern read not queued");

   property p_latency;
      push |=> q_due_r[$past(q_wp_r)] == 8'($past(ck_cnt_r) + $past(rl));
   endproperty
   a_latency: assert property (p_latency) // R12
      else $error("read due time is not one read latency");

   property p_strobe;
      dq_oe_o |-> dqs_oe_o && dqs_o == ~beat_r[0];
   endproperty
   a_strobe: assert property (p_strobe) // R15
      else $error("strobe not running with read data");

   property p_serial;
      (dq_oe_o && bst_fmt_r == FMT_SERIAL) |->
         (dq_o == '0 || dq_o == '1);
   endproperty
   a_serial: assert property (p_serial) // R16
      else $error("serial lanes differ");

   property p_parallel;
      (ck_fall && state_r == ST_BURST && bst_fmt_r == FMT_PARALLEL) |=>
         $stable(dq_o) && dq_o[0] == bst_word_r[7];
   endproperty
   a_parallel: assert property (p_parallel) // R18
      else $error("parallel lane changed or wrong bit");

   property p_upper;
      (dq_oe_o && bst_fmt_r == FMT_PARALLEL) |->
         dq_o[DQ_W-1 -: 8] == dq_o[7:0];
   endproperty
   a_upper: assert property (p_upper) // R19
      else $error("upper byte does not repeat lower byte");

   property p_no_invert;
      (dq_oe_o && bst_fmt_r == FMT_SERIAL && !bst_half_r) |->
         dq_o[0] == bst_word_r[8*bst_loc_r + 7 - beat_r];
   endproperty
   a_no_invert: assert property (p_no_invert) // R20
      else $error("serial data inverted or misordered");

   property p_half;
      (dq_oe_o && bst_fmt_r == FMT_SERIAL && bst_half_r) |->
         dq_o[0] == bst_word_r[8*bst_loc_r + 3 - beat_r];
   endproperty
   a_half: assert property (p_half) // R10
      else $error("chop upper half beats wrong");

   property p_stagger;
      (dq_oe_o && bst_fmt_r == FMT_STAGGER) |->
         dq_o[1] == bst_word_r[8*2'(bst_loc_r + 2'h1) + 7 - beat_r -
                               4*bst_half_r];
   endproperty
   a_stagger: assert property (p_stagger) // R21
      else $error("staggered lane one wrong location");

   c_serial: cover property (start && fmt_r == FMT_SERIAL);
   c_parallel: cover property (start && fmt_r == FMT_PARALLEL);
   c_stagger: cover property (start && fmt_r == FMT_STAGGER);
   c_chop: cover property (start && q_chop_r[q_rp_r]);
   c_seamless: cover property (start && state_r == ST_BURST);

endmodule

// [dprr_pkg.sv]
package dprr_pkg;

   // Register offsets (byte addresses on the APB).
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_PAT = 8'h10;

   // Control register fields and reset values.
   localparam int LAT_W = 6;
   localparam int CTL_CL_LSB = 0;
   localparam int CTL_AL_LSB = 6;
   localparam int CTL_PRE_BIT = 12;
   localparam logic [5:0] CL_RST = 6'h0b;
   localparam logic [5:0] AL_RST = 6'h00;
   localparam logic PRE_RST = 1'h0;

   // Status register fields.
   localparam int SB_EN = 0;
   localparam int SB_PAGE = 1;
   localparam int SB_FMT = 3;
   localparam int SB_BL = 5;
   localparam int SB_DBI = 7;
   localparam int SB_BUSY = 8;
   localparam int SB_FERR = 9;
   localparam int SB_OVF = 10;

   // Positions inside the synchronised pin vector.
   localparam int PIN_W = 21;
   localparam int ADDR_W = 14;
   localparam int P_ADDR = 0;
   localparam int P_BA = 14;
   localparam int P_BG0 = 16;
   localparam int P_WR = 17;
   localparam int P_RD = 18;
   localparam int P_MRS = 19;
   localparam int P_CK = 20;

   // Mode register numbers and their bits.
   localparam logic [2:0] MR_ZERO = 3'h0;
   localparam logic [2:0] MR_THREE = 3'h3;
   localparam logic [2:0] MR_FIVE = 3'h5;
   localparam int M0_BL = 0;
   localparam int M3_PAGE = 0;
   localparam int M3_EN = 2;
   localparam int M3_FMT = 11;
   localparam int M5_DBI = 12;
   localparam int A_HALF = 2;
   localparam int A_CHOP = 12;

   // Burst length codes of mode register zero.
   localparam logic [1:0] BL_FIX8 = 2'h0;
   localparam logic [1:0] BL_OTF = 2'h1;
   localparam logic [1:0] BL_FIX4 = 2'h2;

   // Page zero defaults, location 0 in the low byte.
   localparam logic [31:0] PAT_PAGE0_RST = 32'h000f3355;

   // Beat index of the last beat of each burst kind.
   localparam logic [2:0] LAST_BL8 = 3'h7;
   localparam logic [2:0] LAST_BC4 = 3'h3;

   typedef enum logic [1:0] {
      FMT_SERIAL = 2'h0,
      FMT_PARALLEL = 2'h1,
      FMT_STAGGER = 2'h2,
      FMT_RSVD = 2'h3
   } dprr_fmt_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_PRE = 3'h2,
      ST_BURST = 3'h4
   } dprr_state_t;

endpackage

// [dprr_pat_mem.sv]
`timescale 1ns/1ns
module dprr_pat_mem import dprr_pkg::*; #(
   parameter int W = 32,
   parameter int D = 4,
   parameter int AW = 2
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Write port
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [W/8-1:0] wbe_i,
   input wire logic [W-1:0] wdata_i,
   // Read port
   input wire logic [AW-1:0] raddr_i,
   output logic [W-1:0] rdata_o
);

   logic [W-1:0] mem_r [D];

   // Reset stands for re-initialisation, so the defaults come back.
   genvar g;
   for (g = 0; g < D; g++) begin : g_word
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            mem_r[g] <= (g == 0) ? W'(PAT_PAGE0_RST) : '0;
         end else if (we_i && waddr_i == AW'(g)) begin
            for (int b = 0; b < W/8; b++) begin
               if (wbe_i[b]) begin
                  mem_r[g][8*b +: 8] <= wdata_i[8*b +: 8];
               end
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= '0;
      end else begin
         rdata_o <= mem_r[raddr_i];
      end
   end

   property p_page0_default;
      @(posedge clk_i) disable iff (rst_i)
         $past(rst_i) |-> mem_r[0] == W'(PAT_PAGE0_RST);
   endproperty
   a_page0_default: assert property (p_page0_default) // R1
      else $error("page zero lost its default patterns after reset");

endmodule

// [dprr_ctl_model.sv]
`timescale 1ns/1ns
module dprr_ctl_model import dprr_pkg::*; (
   // Bench clock
   input wire logic mclk_i,
   // Command pins toward the device
   output logic ck_o,
   output logic mrs_o,
   output logic rd_o,
   output logic wr_o,
   output logic bg0_o,
   output logic [1:0] ba_o,
   output logic [ADDR_W-1:0] addr_o
);
   // The command clock runs free, as a memory clock does.
   initial begin
      ck_o = 1'b0;
      {mrs_o, rd_o, wr_o} = 3'h0;
      {bg0_o, ba_o} = 3'h5;
      addr_o = 14'h2aaa;
   end
   always begin
      #62 ck_o = ~ck_o;
      #63 ck_o = ~ck_o;
   end

   // Pins change at the first bench clock rise after a falling edge and hold across the rise.
   // Released address and group lines show the inverse, so a stale value is never reused; command lines return to zero.
   task automatic cmd(input logic [2:0] kind, input logic [2:0] grp,
                      input logic [ADDR_W-1:0] a, input int gap);
      @(negedge ck_o);
      @(posedge mclk_i);
      {mrs_o, rd_o, wr_o} <= kind;
      {bg0_o, ba_o} <= grp;
      addr_o <= (kind == 3'h2) ? {a[13:2], 2'h0} : a;
      @(negedge ck_o);
      @(posedge mclk_i);
      {mrs_o, rd_o, wr_o} <= 3'h0;
      {bg0_o, ba_o} <= ~grp;
      addr_o <= ~a;
      repeat (gap - 1) @(posedge ck_o);
   endtask
endmodule

// [testbench.sv]
`timescale 1ns/1ns
module testbench import dprr_pkg::*; ;
   localparam int DQW = 16;
   localparam int RL = 13;
   localparam int SHORT = 4;
   localparam int LONG = 6;
   localparam int WAIT = 24;
   logic mclk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, ck_i, mrs_i, rd_i, wr_i, bg0_i;
   logic [1:0] ba_i;
   logic [ADDR_W-1:0] addr_i;
   logic [DQW-1:0] dq_o;
   logic dq_oe_o, dqs_o, dqs_oe_o;
   logic [31:0] pages [4];
   logic [32:0] apb_q [$];
   logic [17:0] beat_q [$];
   int lat_q [$];
   int miscompares = 0;
   int cmp_count = 0;
   int rises = 0;
   int edge_wait = 0;
   logic ck_seen = 1'b0;
   logic [1:0] strobe_prev = 2'h0;

   always #5 mclk_i = ~mclk_i;

   dprr_top #(.DQ_W(DQW), .QD(8)) uut (.mclk_i, .sys_rst_i, .psel_i,
      .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
      .pslverr_o, .ck_i, .mrs_i, .rd_i, .wr_i, .bg0_i, .ba_i, .addr_i,
      .dq_o, .dq_oe_o, .dqs_o, .dqs_oe_o);
   dprr_ctl_model ctl (.mclk_i, .ck_o(ck_i), .mrs_o(mrs_i), .rd_o(rd_i),
      .wr_o(wr_i), .bg0_o(bg0_i), .ba_o(ba_i), .addr_o(addr_i));

   task automatic check(input string what, input logic [32:0] e,
                        input logic [32:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s exp %h got %h", what, e, g);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [32:0] e);
      apb_q.push_back(e);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      while (pready_o !== 1'b1) @(posedge mclk_i);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge mclk_i);
   endtask

   task automatic mr3(input logic en, input logic [1:0] fmt,
                      input logic [1:0] pg);
      ctl.cmd(3'h4, MR_THREE, {1'b0, fmt, 8'h00, en, pg}, WAIT);
   endtask

   // Notes the beats a read should return, then issues it.
   task automatic rd_exp(input logic [1:0] fmt, input int pg,
      input logic [1:0] loc, input int first, input int n,
      input logic [13:0] a, input int gap);
      logic [DQW-1:0] v;
      for (int u = first; u < first + n; u++) begin
         for (int i = 0; i < DQW; i++) begin
            if (fmt == 2'h1) v[i] = pages[pg][7 - i % 8];
            else if (fmt == 2'h2) v[i] = pages[pg][8 * ((loc + i % 4) % 4) + 7 - u];
            else v[i] = pages[pg][8 * loc + 7 - u];
         end
         beat_q.push_back({u == first, ~u[0], v});
      end
      ctl.cmd(3'h2, {1'b0, loc}, a, gap);
   endtask

   // Lanes are sampled five cycles after each seen link edge, mid-beat.
   always @(negedge mclk_i) begin
      logic [17:0] e;
      if (ck_i !== ck_seen) begin
         edge_wait = 6;
         if (ck_i === 1'b1) rises++;
         if (ck_i === 1'b1 && rd_i === 1'b1) lat_q.push_back(rises + RL);
      end
      ck_seen = ck_i;
      if (edge_wait > 0) begin
         edge_wait--;
         if (edge_wait == 0) begin
            if (dq_oe_o === 1'b1) begin
               e = (beat_q.size() > 0) ? beat_q.pop_front() : 'x;
               check("lanes", 33'(e[16:0]), {16'h0, dqs_o, dq_o});
               if (e[17] === 1'b1) begin
                  check("latency", 33'(lat_q.pop_front()), 33'(rises));
                  check("preamble", 33'h2, {31'h0, strobe_prev});
               end
            end
            strobe_prev = {dqs_oe_o, dqs_o};
         end
      end
   end

   always @(posedge mclk_i) begin
      if (pready_o === 1'b1)
         check("apb", (apb_q.size() > 0) ? apb_q.pop_front() : 'x,
               {pslverr_o, prdata_o});
   end

   initial begin
      #400000;
      miscompares++;
      stop_test();
   end

   initial begin
      logic [7:0] b;
      void'($urandom(32'h90a3));
      repeat (8) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      pages[0] = 32'h000f3355;
      for (int k = 1; k < 4; k++) pages[k] = $urandom;
      apb(0, REG_CTRL, 0, 33'h0b);
      apb(0, REG_PAT, 0, {1'b0, pages[0]});
      apb(1, REG_PAT, 32'hffffffff, 33'h100000000);
      apb(1, 8'h20, 0, 33'h100000000);
      apb(1, REG_CTRL, 32'h108b, 33'h0);
      for (int k = 1; k < 4; k++) apb(1, REG_PAT + 8'(4 * k), pages[k], 33'h0);
      apb(0, REG_PAT + 8'h4, 0, {1'b0, pages[1]});
      $display("test registers done");
      // Reset leaves every bank idle, so precharge is already met.
      mr3(1, 2'h0, 2'h0);
      for (int k = 0; k < 4; k++)
         rd_exp(2'h0, 0, 2'(k), 0, 8, 14'h0, k == 3 ? WAIT : SHORT);
      mr3(1, 2'h3, 2'h0);
      apb(0, REG_STAT, 0, 33'h201);
      rd_exp(2'h0, 0, 2'h1, 0, 8, 14'h0, LONG);
      b = 8'($urandom);
      ctl.cmd(3'h1, 3'h2, {6'h0, b}, LONG);
      pages[0][23:16] = b;
      apb(0, REG_PAT, 0, {1'b0, pages[0]});
      rd_exp(2'h0, 0, 2'h2, 0, 8, 14'h0, WAIT);
      $display("test serial done");
      mr3(1, 2'h2, 2'h0);
      for (int k = 0; k < 3; k++)
         rd_exp(2'h2, 0, 2'($urandom), 0, 8, 14'h0,
                k == 2 ? WAIT : LONG);
      mr3(1, 2'h1, 2'h0);
      rd_exp(2'h1, 0, 2'h0, 0, 8, 14'h0, WAIT);
      $display("test formats done");
      ctl.cmd(3'h4, MR_ZERO, 14'h2, WAIT);
      mr3(1, 2'h0, 2'h3);
      rd_exp(2'h0, 3, 2'h1, 4, 4, 14'h4, LONG);
      rd_exp(2'h0, 3, 2'h2, 0, 4, 14'h0, WAIT);
      ctl.cmd(3'h4, MR_ZERO, 14'h1, WAIT);
      rd_exp(2'h0, 3, 2'h3, 0, 8, 14'h1000, WAIT);
      ctl.cmd(3'h4, MR_FIVE, 14'h1000, WAIT);
      mr3(1, 2'h0, 2'h2);
      rd_exp(2'h0, 2, 2'h0, 0, 8, 14'h1000, WAIT);
      $display("test bursts done");
      mr3(0, 2'h0, 2'h3);
      ctl.cmd(3'h2, 3'h0, 14'h0, WAIT);
      check("beats left", 33'h0, 33'(beat_q.size()));
      $display("test exit done");
      stop_test();
   end
endmodule
